// ==== hw/micro_load_pkg.sv ====
// constants shared by the micro holding register load logic
// assumes a single 50 MHz processor clock and an active-high asynchronous reset
`default_nettype none
package micro_load_pkg;
  localparam int MICRO_WIDTH    = 16;
  localparam int LATCH_WIDTH    = 32;
  localparam int EXCH_WIDTH     = 24;
  localparam int ADDR_WIDTH     = 24;
  localparam int LIT_LOW_WIDTH  = 8;
  localparam int BRANCH_SHIFT   = 4;
  localparam int LIT_HIGH_POS   = 16;
  localparam int ADDR_CARRY_POS = 4;
  localparam int NOOP_CLOCKS    = 2;
  localparam logic [15:0] HOLD_RESET  = 16'h0000;
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [23:0] ADDR_RESET  = 24'h00_0000;
  localparam logic [23:0] ADDR_STEP   = 24'h00_0010;
  // avalon map, word offsets are byte addresses
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_ADDR    = 4'h8;
  localparam int CTRL_RUN_POS  = 0;
  localparam int CTRL_HOLD_POS = 1;
  localparam int CTRL_MTR_POS  = 2;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage
`default_nettype wire

// ==== hw/micro_latch_buffer.sv ====
// micro latch buffer: two micros captured from a memory fetch
// assumes fetch data valid in the cycle that micro_fetch_cycle is high
`default_nettype none
module micro_latch_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             micro_fetch_cycle,
  input  wire logic [WIDTH-1:0] fetch_data,
  input  wire logic             address_bit_four,
  output var  logic [WIDTH-1:0] latch,
  output wire logic [WIDTH/2-1:0] half_reversed
);
  // the half select and bit reversal assume two 16-bit micros per word
  if (WIDTH != 32) begin : g_bad_width
    $error("latch buffer must be 32 bits");
  end

  // refresh cycles leave the buffer alone; only a fetch writes it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) latch <= micro_load_pkg::LATCH_RESET;
    else if (micro_fetch_cycle) latch <= fetch_data;
  end

  wire logic [WIDTH/2-1:0] sel_half;
  assign sel_half = address_bit_four ? latch[WIDTH-1:WIDTH/2] : latch[WIDTH/2-1:0];

  // msb of the micro sits at latch bit 0 of the half
  genvar i;
  generate
    for (i = 0; i < WIDTH/2; i++) begin : g_rev
      assign half_reversed[i] = sel_half[WIDTH/2-1-i];
    end
  endgenerate

  lat_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(micro_fetch_cycle) |-> latch == $past(latch))
    else $error("latch changed without a fetch");
  lat_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    micro_fetch_cycle |=> latch == $past(fetch_data))
    else $error("fetch data not captured");
endmodule
`default_nettype wire

// ==== hw/micro_register_load_logic.sv ====
// micro holding register, its sources, and its gating onto the exchange
// assumes micro decode inputs, tape word and fetch data are synchronous to clk_sys
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`default_nettype none
// What this block does
// - type one or two move sourcing holding register drives bits 0-15 to exchange.
// - taken branch micros place holding register on exchange shifted up four.
// - short literal gates only bits 0-7 onto exchange bits 0-7.
// - move literal in run or full tape execute puts bits 0-7 on exchange 16-23.
// - literal low 16 bits come from latch in run, tape register in tape mode.
// - each holding input ORs gated tape, exchange and latch-half sources.
// - exchange and latch both gated load their bitwise OR at the clock.
// - loads happen only under parallel load enable; otherwise the register holds.
// - latch buffer is 32 bits, two 16-bit micro halves.
// - micro fetch sends word address and captures 32 bits into the latch.
// - each fetch adds sixteen via carry into address bit four.
// - address bit four picks latch half, transferred bit reversed under gate enable.
// - refresh cycles leave the latch buffer untouched.
// - after move literal the register clears, forcing a two clock no-op.
// - tape select only in tape mode, one clock at slot one when word full.
// - tape select gates low tape bits and enables reading upper eight bits.
// - literal follow flag set by tape move literal blocks load, routes bits to exchange.
// - types one, two, ten sinking holding register at finish outside tape execute mode assert three selects.
// - holding register is 16 bits, cleared on processor clear or literal/tape finish.
// - holding outputs gated by run and not-hold drive the distribution bus.
module micro_register_load_logic (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // micro decode
  input  wire logic        register_move_type_one,
  input  wire logic        register_move_type_two,
  input  wire logic        register_move_type_ten,
  input  wire logic        conditional_branch_a,
  input  wire logic        conditional_branch_b,
  input  wire logic        branch_taken,
  input  wire logic        relative_branch_micro,
  input  wire logic        relative_call_micro,
  input  wire logic        short_literal_micro,
  input  wire logic        move_literal_micro,
  input  wire logic        holding_is_source,
  input  wire logic        holding_is_sink,
  input  wire logic        micro_finish,
  input  wire logic        general_processor_clear,
  input  wire logic        timing_slot_one,
  // tape assembly
  input  wire logic        tape_word_full,
  input  wire logic [23:0] tape_word,
  // memory
  input  wire logic        micro_fetch_cycle,
  input  wire logic [31:0] fetch_data,
  output logic      [23:0] memory_word_address,
  // exchange
  input  wire logic [23:0] exchange_in,
  output logic      [23:0] exchange_out,
  output logic             exchange_drive,
  output logic      [15:0] micro_distribution_bus,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  // control register: run, hold, tape execute mode
  logic [2:0]  ctrl;
  logic [15:0] holding;
  logic [23:0] addr_ptr;
  logic        literal_follow_flag;
  logic        tape_slot_done;
  micro_load_pkg::bus_state_t bus_state;
  wire logic [31:0] latch;
  wire logic [15:0] latch_half;

  wire logic run_state         = ctrl[micro_load_pkg::CTRL_RUN_POS];
  wire logic not_hold          = !ctrl[micro_load_pkg::CTRL_HOLD_POS];
  wire logic tape_execute_mode = ctrl[micro_load_pkg::CTRL_MTR_POS];
  wire logic address_bit_four  = addr_ptr[micro_load_pkg::ADDR_CARRY_POS];

  micro_latch_buffer #(.WIDTH(micro_load_pkg::LATCH_WIDTH)) u_latch (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .micro_fetch_cycle (micro_fetch_cycle),
    .fetch_data        (fetch_data),
    .address_bit_four  (address_bit_four),
    .latch             (latch),
    .half_reversed     (latch_half)
  );

  // select generation
  wire logic move_sink = (register_move_type_one | register_move_type_two |
                          register_move_type_ten) & holding_is_sink;
  wire logic sink_finish = move_sink & micro_finish & !tape_execute_mode;
  wire logic tape_to_micro_select = tape_execute_mode & tape_word_full &
                                    timing_slot_one & !tape_slot_done;
  wire logic exchange_to_micro_select = sink_finish;
  wire logic latch_gate_enable = sink_finish | (!tape_execute_mode & micro_fetch_cycle &
                                 !move_literal_micro);
  wire logic latch_low_half_enable  = latch_gate_enable & !address_bit_four;
  wire logic latch_high_half_enable = latch_gate_enable & address_bit_four;
  wire logic parallel_load_enable = (sink_finish | latch_gate_enable |
                                     tape_to_micro_select) & !literal_follow_flag;

  // tape upper eight bits readable only under the tape select
  wire logic [7:0] tape_upper = tape_to_micro_select ? tape_word[23:16] : 8'h00;

  // three-way OR of gated sources
  wire logic [15:0] tape_src  = tape_to_micro_select ? tape_word[15:0] : 16'h0000;
  wire logic [15:0] exch_src  = exchange_to_micro_select ? exchange_in[15:0] : 16'h0000;
  wire logic [15:0] latch_src = (latch_low_half_enable | latch_high_half_enable) ?
                                latch_half : 16'h0000;
  wire logic [15:0] next_input = tape_src | exch_src | latch_src;

  wire logic literal_finish = move_literal_micro & micro_finish;
  wire logic tape_finish    = tape_execute_mode & tape_slot_done & micro_finish;
  wire logic holding_register_clear = general_processor_clear | literal_finish |
                                      tape_finish;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) holding <= micro_load_pkg::HOLD_RESET;
    else if (holding_register_clear) holding <= micro_load_pkg::HOLD_RESET;
    else if (parallel_load_enable) holding <= next_input;
  end

  // one slot-one pulse per full tape word
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) tape_slot_done <= 1'b0;
    else tape_slot_done <= tape_word_full & (tape_slot_done | tape_to_micro_select);
  end

  // literal follow flag: set by tape move literal, cleared when literal word consumed
  wire logic literal_word_used = literal_follow_flag & tape_word_full & timing_slot_one;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) literal_follow_flag <= 1'b0;
    else if (tape_execute_mode & move_literal_micro & micro_finish)
      literal_follow_flag <= 1'b1;
    else if (literal_word_used) literal_follow_flag <= 1'b0;
  end

  // register writes take effect in the acknowledge cycle only
  wire logic bus_write_ctrl = avs_write & bus_state == micro_load_pkg::BUS_ACK &
                              avs_address == micro_load_pkg::REG_CTRL;
  wire logic bus_write_addr = avs_write & bus_state == micro_load_pkg::BUS_ACK &
                              avs_address == micro_load_pkg::REG_ADDR;

  // address pointer: plus sixteen per fetch, word address presented
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) addr_ptr <= micro_load_pkg::ADDR_RESET;
    else if (bus_write_addr) addr_ptr <= avs_writedata[23:0];
    else if (micro_fetch_cycle) addr_ptr <= addr_ptr + micro_load_pkg::ADDR_STEP;
  end

  // exchange gating
  wire logic run_or_full = run_state | (tape_execute_mode & tape_word_full);
  wire logic gate_move   = (register_move_type_one | register_move_type_two) &
                           holding_is_source;
  wire logic gate_branch = relative_branch_micro | relative_call_micro |
                           ((conditional_branch_a | conditional_branch_b) & branch_taken);
  wire logic gate_lit    = move_literal_micro & run_or_full;
  wire logic tape_lit    = literal_follow_flag & tape_word_full;
  wire logic [15:0] lit_low = tape_execute_mode ? tape_word[15:0] : latch_half;
  logic [23:0] next_exchange;
  logic        next_drive;
  always_comb begin
    next_exchange = 24'h00_0000;
    next_drive    = 1'b1;
    if (gate_move) next_exchange = {8'h00, holding};
    else if (gate_branch) next_exchange = {4'h0, holding, 4'h0};
    else if (short_literal_micro) next_exchange = {16'h0000, holding[7:0]};
    else if (gate_lit) next_exchange = {holding[7:0], lit_low};
    else if (tape_lit) next_exchange = {tape_upper, tape_word[15:0]};
    else next_drive = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      exchange_out           <= 24'h00_0000;
      exchange_drive         <= 1'b0;
      micro_distribution_bus <= 16'h0000;
      memory_word_address    <= micro_load_pkg::ADDR_RESET;
    end else begin
      exchange_out           <= next_exchange;
      exchange_drive         <= next_drive;
      micro_distribution_bus <= holding & {16{run_state & not_hold}};
      memory_word_address    <= {addr_ptr[23:2], 2'b00};
    end
  end

  // avalon slave: one wait cycle, then ack
  wire logic bus_req    = (avs_read | avs_write) & (bus_state == micro_load_pkg::BUS_IDLE);
  logic [31:0] next_readdata;
  always_comb begin
    case (avs_address)
      micro_load_pkg::REG_CTRL:   next_readdata = {29'h0, ctrl};
      micro_load_pkg::REG_STATUS: next_readdata = {14'h0, literal_follow_flag,
                                                   address_bit_four, holding};
      micro_load_pkg::REG_ADDR:   next_readdata = {8'h00, addr_ptr};
      default:                    next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state       <= micro_load_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        micro_load_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_state       <= micro_load_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= next_readdata;
          end
        end
        micro_load_pkg::BUS_ACK: begin
          bus_state       <= micro_load_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: bus_state <= micro_load_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) ctrl <= micro_load_pkg::CTRL_RESET;
    else if (bus_write_ctrl) ctrl <= avs_writedata[2:0];
  end

  // checks
  clr_literal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    literal_finish |=> holding == 16'h0000)
    else $error("holding not cleared after literal");
  load_or_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    parallel_load_enable & !holding_register_clear |=> holding == $past(next_input))
    else $error("holding did not load gated sources");
  hold_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !parallel_load_enable & !holding_register_clear |=> $stable(holding))
    else $error("holding changed without load");
  tape_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tape_to_micro_select |=> !tape_to_micro_select)
    else $error("tape select longer than one clock");
  tape_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tape_to_micro_select |-> tape_execute_mode)
    else $error("tape select outside tape mode");
  follow_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    literal_follow_flag |-> !parallel_load_enable)
    else $error("load enabled while literal follows");
  addr_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    micro_fetch_cycle & !bus_write_addr |=> address_bit_four != $past(address_bit_four))
    else $error("address bit four did not toggle");
  exch_move_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gate_move |=> exchange_out == {8'h00, $past(holding)})
    else $error("move micro exchange mismatch");
  exch_branch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gate_branch & !gate_move |=> exchange_out == {4'h0, $past(holding), 4'h0})
    else $error("branch exchange not shifted");
  sink_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sink_finish & !literal_follow_flag |-> exchange_to_micro_select & latch_gate_enable
    & parallel_load_enable)
    else $error("sink selects not asserted together");
  dist_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(run_state & not_hold) |=> micro_distribution_bus == 16'h0000)
    else $error("distribution bus not gated");

  // exchange contents per gating micro
  exch_short_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    short_literal_micro & !gate_move & !gate_branch |=>
    exchange_out == {16'h0000, $past(holding[7:0])})
    else $error("short literal exchange mismatch");
  exch_lit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gate_lit & !gate_move & !gate_branch & !short_literal_micro |=>
    exchange_out[23:16] == $past(holding[7:0]))
    else $error("literal upper byte mismatch");
  lit_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gate_lit & !gate_move & !gate_branch & !short_literal_micro & !tape_execute_mode |=>
    exchange_out[15:0] == $past(latch_half))
    else $error("literal low half not from latch");
  drive_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(gate_move | gate_branch | short_literal_micro | gate_lit | tape_lit) |=>
    !exchange_drive)
    else $error("exchange driven without a gating micro");

  // holding register sources
  sink_or_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sink_finish & !literal_follow_flag & !holding_register_clear & !tape_to_micro_select
    |=> holding == $past(exchange_in[15:0] | latch_half))
    else $error("sink load is not the or of both sources");
  tape_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tape_to_micro_select & !holding_register_clear & !literal_follow_flag |=>
    holding == $past(tape_word[15:0]))
    else $error("tape word not loaded");
  clr_gp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    general_processor_clear |=> holding == 16'h0000)
    else $error("processor clear missed");
  half_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    latch_gate_enable |-> latch_low_half_enable != latch_high_half_enable)
    else $error("latch half enables not exclusive");
  half_hi_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    address_bit_four |-> latch_half[15] == latch[16])
    else $error("upper latch half not reversed");
  half_lo_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !address_bit_four |-> latch_half[15] == latch[0])
    else $error("lower latch half not reversed");

  // flags and outputs
  follow_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tape_execute_mode & move_literal_micro & micro_finish |=> literal_follow_flag)
    else $error("literal follow flag not set");
  dist_pass_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run_state & not_hold |=> micro_distribution_bus == $past(holding))
    else $error("distribution bus does not follow holding");
  word_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> memory_word_address[23:2] == $past(addr_ptr[23:2]))
    else $error("word address not presented");

  cov_sink: cover property (@(posedge clk_sys) disable iff (sys_rst) sink_finish);
  cov_follow: cover property (@(posedge clk_sys) disable iff (sys_rst) tape_lit);
  cov_branch: cover property (@(posedge clk_sys) disable iff (sys_rst) gate_branch);
  cov_literal: cover property (@(posedge clk_sys) disable iff (sys_rst) gate_lit);
  cov_tape: cover property (@(posedge clk_sys) disable iff (sys_rst) tape_to_micro_select);
endmodule
`default_nettype wire

// ==== testbench/fetch_memory_model.sv ====
// memory side of the micro fetch path: answers each fetch with a fixed pattern
// assumes read data is expected in the same cycle as the fetch strobe
`default_nettype none
module fetch_memory_model (
  input  wire logic        clk_sys,
  input  wire logic        micro_fetch_cycle,
  input  wire logic [23:0] memory_word_address,
  output logic      [31:0] fetch_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] last;
  logic [31:0] word;
  // two micros per word, derived from the word address
  assign word = {memory_word_address[15:0] ^ 16'hC3A5, memory_word_address[15:0] ^ 16'h5A3C};
  // outside a fetch the data lines show the inverse of the last word, never a stale copy
  assign fetch_data = micro_fetch_cycle ? word : ~last;
  always_ff @(posedge clk_sys) begin
    if (micro_fetch_cycle) begin
      last <= word;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/micro_register_load_logic_tb.sv ====
// self-checking bench for the micro holding register load logic
// assumes the avalon map and one-cycle answer described for the block
`default_nettype none
module micro_register_load_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, mv_one, mv_two, mv_ten, cb_a, cb_b, taken, rel_br, rel_call;
  logic short_lit, move_lit, src, sink, finish, gp_clear, slot_one, tape_full, fetch;
  logic        exchange_drive, avs_read, avs_write, avs_waitrequest;
  logic [23:0] tape_word, mem_addr, exchange_in, exchange_out;
  logic [31:0] fetch_data, avs_writedata, avs_readdata, rd;
  logic [15:0] micro_distribution_bus, hold;
  logic [3:0]  avs_address;
  int          err_total;
  int          checked;

  micro_register_load_logic i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .register_move_type_one(mv_one),
    .register_move_type_two(mv_two), .register_move_type_ten(mv_ten),
    .conditional_branch_a(cb_a), .conditional_branch_b(cb_b), .branch_taken(taken),
    .relative_branch_micro(rel_br), .relative_call_micro(rel_call),
    .short_literal_micro(short_lit), .move_literal_micro(move_lit), .holding_is_source(src),
    .holding_is_sink(sink), .micro_finish(finish), .general_processor_clear(gp_clear),
    .timing_slot_one(slot_one), .tape_word_full(tape_full), .tape_word(tape_word),
    .micro_fetch_cycle(fetch), .fetch_data(fetch_data), .memory_word_address(mem_addr),
    .exchange_in(exchange_in), .exchange_out(exchange_out), .exchange_drive(exchange_drive),
    .micro_distribution_bus(micro_distribution_bus), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  fetch_memory_model i_mem (.clk_sys(clk_sys), .micro_fetch_cycle(fetch),
    .memory_word_address(mem_addr), .fetch_data(fetch_data));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // holds the request until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) check(1'b1, 1'b0, "bus answer missing");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    tick(1);
  endtask

  task automatic idle_decode();
    {mv_one, mv_two, mv_ten, cb_a, cb_b, taken, rel_br, rel_call} <= 8'h00;
    {short_lit, move_lit, src, sink, finish, gp_clear, slot_one} <= 7'h00;
  endtask

  function automatic logic [15:0] rev_half(input logic [31:0] l, input logic hi);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = hi ? l[31-i] : l[15-i];
    return r;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    conclude();
  end

  initial begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    {mv_one, mv_two, mv_ten, cb_a, cb_b, taken, rel_br, rel_call} = 8'h00;
    {short_lit, move_lit, src, sink, finish, gp_clear, slot_one, tape_full, fetch} = 9'h000;
    {avs_read, avs_write, avs_address, avs_writedata} = 38'h0;
    tape_word = 24'h00_0000;
    exchange_in = 24'h00_0000;
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    check(avs_waitrequest, 1'b1, "waitrequest at reset");
    check({exchange_drive, exchange_out, micro_distribution_bus}, 32'h0, "outputs at reset");
    bus(1'b0, micro_load_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // one fetch from word address zero fills the latch and steps the pointer
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(2);
    check(mem_addr, micro_load_pkg::ADDR_STEP, "word address after fetch");
    bus(1'b0, micro_load_pkg::REG_ADDR, 32'h0);
    check(rd[23:0], micro_load_pkg::ADDR_STEP, "pointer plus sixteen");
    // exchange and upper latch half OR into the holding register at finish
    exchange_in <= 24'hFF_0810;
    mv_one <= 1'b1;
    sink <= 1'b1;
    finish <= 1'b1;
    tick(1);
    idle_decode();
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    hold = 16'h0810 | rev_half(32'hC3A5_5A3C, 1'b1);
    check(rd[16:0], {1'b1, hold}, "holding after exchange sink");
    // without finish the sink micro must not load
    exchange_in <= 24'h00_F00F;
    mv_two <= 1'b1;
    sink <= 1'b1;
    tick(2);
    idle_decode();
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[15:0], hold, "holding kept outside load");
    src <= 1'b1;
    mv_one <= 1'b1;
    tick(2);
    check({exchange_drive, exchange_out[15:0]}, {1'b1, hold}, "holding as source");
    idle_decode();
    for (int k = 0; k < 4; k++) begin
      tick(1);
      {cb_b, cb_a, rel_call, rel_br} <= 4'h1 << k;
      taken <= 1'b1;
      tick(2);
      check(exchange_out[19:0], {hold, 4'h0}, "branch offset shifted by four");
      idle_decode();
    end
    tick(1);
    short_lit <= 1'b1;
    tick(2);
    check(exchange_out, {16'h0000, hold[7:0]}, "short literal low byte only");
    idle_decode();
    bus(1'b1, micro_load_pkg::REG_CTRL, 32'h3);
    tick(2);
    check(micro_distribution_bus, 16'h0000, "distribution bus blocked in hold");
    bus(1'b1, micro_load_pkg::REG_CTRL, 32'h1);
    tick(2);
    check(micro_distribution_bus, hold, "distribution bus in run");
    // a full tape word outside tape execute mode must not reach the holding register
    tape_word <= 24'hAB_5A96;
    tape_full <= 1'b1;
    slot_one <= 1'b1;
    tick(1);
    slot_one <= 1'b0;
    tape_full <= 1'b0;
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[15:0], hold, "tape ignored outside tape mode");
    move_lit <= 1'b1;
    tick(2);
    check(exchange_out[23:16], hold[7:0], "literal upper byte");
    check(exchange_out[15:0], rev_half(32'hC3A5_5A3C, 1'b1), "literal low from latch");
    finish <= 1'b1;
    tick(1);
    idle_decode();
    tick(2);
    check(micro_distribution_bus, 16'h0000, "no-op after move literal");
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[15:0], 16'h0000, "holding cleared at literal finish");
    // tape execute mode: one slot-one pulse sets the low tape bits
    bus(1'b1, micro_load_pkg::REG_CTRL, 32'h4);
    tape_full <= 1'b1;
    slot_one <= 1'b1;
    tick(1);
    slot_one <= 1'b0;
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[15:0], 16'h5A96, "tape word into holding");
    gp_clear <= 1'b1;
    tick(1);
    gp_clear <= 1'b0;
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[15:0], 16'h0000, "processor clear");
    // a move literal from tape routes the next tape word to the exchange
    move_lit <= 1'b1;
    finish <= 1'b1;
    tick(1);
    idle_decode();
    tick(1);
    bus(1'b0, micro_load_pkg::REG_STATUS, 32'h0);
    check(rd[17], 1'b1, "literal follow flag set");
    tick(1);
    check({exchange_drive, exchange_out[15:0]}, {1'b1, 16'h5A96}, "tape literal low");
    tape_full <= 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
